// ### src/mon_gate_pkg.sv
// Purpose: shared constants and carriers for the monitor security gate
// Assumes: 8-bit bytes on a byte-level monitor link, one system clock
// Notes: byte serialisation on the monitor pin is done outside this block
package mon_gate_pkg;

  // ==========================================================
  // command opcodes and counts
  localparam logic [7:0] RUN_OPCODE = 8'h28;
  localparam logic [7:0] READ_SP_OPCODE = 8'h0c;  // arbitrary code for the stack read
  localparam int unsigned SEC_BYTES = 8;
  localparam logic [3:0] SEC_LAST = 4'h7;

  // ==========================================================
  // addresses and fields
  localparam logic [15:0] SEC_BASE_ADDR = 16'hfff6;
  localparam logic [15:0] SEC_END_ADDR = 16'hfffd;
  localparam logic [7:0] STATUS_RAM_ADDR = 8'h40;
  localparam int unsigned STATUS_OK_BIT = 6;
  localparam logic [7:0] BLANK_BYTE = 8'hff;
  localparam logic [7:0] INVALID_BYTE = 8'had;  // returned on locked flash reads
  localparam logic [15:0] SP_RD_OFS = 16'h0001;
  localparam logic [15:0] PCH_OFS = 16'h0005;
  localparam logic [15:0] PCL_OFS = 16'h0006;
  localparam logic [15:0] SP_RESET = 16'h00ff;

  // ==========================================================
  // gate states
  typedef enum logic [2:0] {
    ST_STACK = 3'b000,
    ST_WAIT_SEC = 3'b001,
    ST_BREAK = 3'b010,
    ST_CMD = 3'b011,
    ST_ECHO = 3'b100,
    ST_RESUME = 3'b101,
    ST_USER = 3'b110
  } gate_state_t;

  // cpu action requests toward the core
  typedef struct packed {
    logic sw_int;
    logic push_h;
    logic pull_h;
    logic int_ret;
  } cpu_req_t;

  // byte on the monitor link
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } link_byte_t;

endpackage : mon_gate_pkg

// ### src/sec_compare.sv
// Purpose: stepwise comparison of received security bytes with flash copy
// Assumes: one byte presented per strobe, in order from the base address
// Notes: any mismatch sticks until the sequence is restarted
`timescale 1ns/1ps
module sec_compare
  import mon_gate_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  input wire logic byte_stb_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic [7:0] flash_byte_i,
  // result
  output logic [3:0] index_o,
  output logic done_o,
  output logic match_o
);

  typedef struct packed {
    logic [3:0] idx;
    logic done;
    logic ok;
  } cmp_state_t;

  cmp_state_t s_r;
  cmp_state_t s_nxt;

  // ==========================================================
  // compare each byte in turn
  always_comb begin
    s_nxt = s_r;
    if (start_i) begin
      s_nxt = '{idx: 4'h0, done: 1'b0, ok: 1'b1};
    end else if (byte_stb_i && !s_r.done) begin
      if (rx_byte_i != flash_byte_i) begin
        s_nxt.ok = 1'b0;
      end
      if (s_r.idx == SEC_LAST) begin
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.idx = s_r.idx + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_r <= '{idx: 4'h0, done: 1'b0, ok: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign index_o = s_r.idx;
  assign done_o = s_r.done;
  assign match_o = s_r.ok && s_r.done;

endmodule : sec_compare

// ### src/monitor_security_gate.sv
// Purpose: monitor mode entry, security gate and run / stack read commands
// Assumes: host keeps its side of the link protocol; flash read by address
// Notes: rst_i is any reset; por_i marks the power-on kind
//   the link is byte level; bit timing and break shaping live in the serial front end
//   the cpu core and the flash array sit outside; this block only sequences and gates them
// Functional notes
// - resume command is opcode 28 hex and is echoed to the host.
// - on monitor entry issue software interrupt then push index high.
// - on resume pull index high then return from interrupt.
// - stack read returns SP plus one; PC bytes at SP+5, SP+6.
// - eight host bytes compare with flash FFF6 through FFFD.
// - after power-on, wait for eight security bytes before anything else.
// - all bytes match grants flash reads and flash execution.
// - unlock survives every reset except power-on.
// - mismatch keeps monitor mode, invalid reads, fetch raises illegal reset.
// - break character only after all eight bytes arrived.
// - set bit 6 of RAM byte 40 hex when code was correct.
// - mass erase leaves all eight security bytes at FF.
`timescale 1ns/1ps
module monitor_security_gate
  import mon_gate_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  // monitor link, byte level
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_break_o,
  // cpu interface
  input wire logic [15:0] sp_i,
  input wire logic cpu_ack_i,
  output cpu_req_t cpu_req_o,
  // flash security window read
  output logic [15:0] sec_addr_o,
  input wire logic [7:0] sec_data_i,
  // flash access gating
  input wire logic flash_rd_i,
  input wire logic [7:0] flash_rdata_i,
  output logic [7:0] flash_rdata_o,
  input wire logic flash_fetch_i,
  output logic illegal_reset_o,
  // mass erase and status
  input wire logic mass_erase_done_i,
  output logic erased_o,
  output logic [7:0] status_ram_o,
  output logic unlocked_o,
  output logic monitor_mode_o
);

  // all gate state in one word; s_nxt is built each cycle and registered
  typedef struct packed {
    gate_state_t st;
    logic unlocked;
    logic sec_done;
    logic erased;
    logic [1:0] step;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_break;
    logic [7:0] pend_lo;
    logic pend_lo_valid;
    cpu_req_t req;
    logic [7:0] rdata;
    logic illegal;
  } gate_reg_t;

  // ==========================================================
  // state and local nets
  gate_reg_t s_r;
  gate_reg_t s_nxt;
  logic cmp_start;
  logic cmp_stb;
  logic [3:0] cmp_idx;
  logic cmp_done;
  logic cmp_match;
  logic [15:0] sp_plus;
  logic tx_taken;
  logic cmd_take;
  logic cmd_is_run;
  logic cmd_is_read_sp;
  logic req_ack;
  logic fetch_blocked;
  logic [7:0] status_img;

  // ==========================================================
  // security comparator
  // restarts on every stacking pass, so a warm reset never mixes old and new bytes
  // only bytes seen while waiting count; anything else is a command or noise
  assign cmp_start = rst_i || (s_r.st == ST_STACK);
  assign cmp_stb = (s_r.st == ST_WAIT_SEC) && rx_valid_i;

  sec_compare sec_compare_i (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .start_i(cmp_start),
    .byte_stb_i(cmp_stb),
    .rx_byte_i(rx_data_i),
    .flash_byte_i(sec_data_i),
    .index_o(cmp_idx),
    .done_o(cmp_done),
    .match_o(cmp_match)
  );

  // flash address of the byte being compared
  // the window is read combinationally, one byte per compare index
  assign sec_addr_o = SEC_BASE_ADDR + {12'h000, cmp_idx};
  assign sp_plus = sp_i + SP_RD_OFS;

  // ==========================================================
  // link handshake and command decode
  // a byte leaves on the edge that sees ready; the next one may load at that edge
  assign tx_taken = s_r.tx_valid && tx_ready_i;
  // commands are only taken with the transmit slot free, so an echo is never lost
  assign cmd_take = (s_r.st == ST_CMD) && rx_valid_i && !s_r.tx_valid;
  assign cmd_is_run = (rx_data_i == RUN_OPCODE);
  assign cmd_is_read_sp = (rx_data_i == READ_SP_OPCODE);

  // ==========================================================
  // cpu handshake and flash gating
  // the core answers each single-step request with one ack pulse
  assign req_ack = cpu_ack_i && (s_r.req != '0);
  // a locked fetch is turned into an illegal address reset request
  assign fetch_blocked = flash_fetch_i && !s_r.unlocked;

  // ==========================================================
  // status byte image: only the success bit follows the gate
  // kept as a loop so further status bits slot in per bit
  for (genvar b = 0; b < 8; b++) begin : g_status
    if (b == STATUS_OK_BIT) begin : g_ok
      assign status_img[b] = s_r.unlocked;
    end else begin : g_zero
      assign status_img[b] = 1'b0;
    end
  end

  // ==========================================================
  // next-state logic
  always_comb begin
    // hold by default; pulses fall back unless set again below
    s_nxt = s_r;
    s_nxt.illegal = 1'b0;
    // handshake release of the transmit byte
    if (tx_taken) begin
      s_nxt.tx_valid = 1'b0;
      s_nxt.tx_break = 1'b0;
    end
    // the low byte of a pair loads on the edge its high byte leaves, so pairs never split
    if (tx_taken && s_r.pend_lo_valid) begin
      s_nxt.tx_valid = 1'b1;
      s_nxt.tx_data = s_r.pend_lo;
      s_nxt.pend_lo_valid = 1'b0;
    end
    // mass erase blanks the security window
    // the array itself is blanked outside; this flag records that it happened
    if (mass_erase_done_i) begin
      s_nxt.erased = 1'b1;
    end
    unique case (s_r.st)
      ST_STACK: begin
        // software interrupt, then push index high
        // the host sees nothing until both stacking steps are acked
        if (s_r.step == 2'b00) begin
          s_nxt.req.sw_int = 1'b1;
          s_nxt.step = 2'b01;
        end else if (req_ack && s_r.req.sw_int) begin
          s_nxt.req.sw_int = 1'b0;
          s_nxt.req.push_h = 1'b1;
        end else if (req_ack && s_r.req.push_h) begin
          s_nxt.req.push_h = 1'b0;
          s_nxt.step = 2'b00;
          // a warm reset with a verdict in hand skips straight to the break
          s_nxt.st = s_r.sec_done ? ST_BREAK : ST_WAIT_SEC;
        end
      end
      ST_WAIT_SEC: begin
        // nothing else runs until eight bytes are in
        // the verdict is taken once, from the comparator's sticky result
        if (cmp_done) begin
          s_nxt.unlocked = cmp_match;
          s_nxt.sec_done = 1'b1;
          s_nxt.st = ST_BREAK;
        end
      end
      ST_BREAK: begin
        // ready signal toward the host
        // sent once per stacking pass, never before the eighth byte
        if (!s_r.tx_valid) begin
          s_nxt.tx_valid = 1'b1;
          s_nxt.tx_break = 1'b1;
          s_nxt.tx_data = 8'h00;
          s_nxt.st = ST_CMD;
        end
      end
      ST_CMD: begin
        // a command that meets a queued byte is dropped; the host paces itself on the echo
        // unknown opcodes are only echoed
        if (cmd_take) begin
          s_nxt.tx_valid = 1'b1;
          s_nxt.tx_data = rx_data_i; // echo of the opcode
          if (cmd_is_run) begin
            s_nxt.st = ST_RESUME;
          end else if (cmd_is_read_sp) begin
            s_nxt.st = ST_ECHO;
          end
        end
      end
      ST_ECHO: begin
        // send SP+1 high then low after the echo
        // the low byte waits in pend_lo until the high byte is taken
        if (!s_r.tx_valid) begin
          s_nxt.tx_valid = 1'b1;
          s_nxt.tx_data = sp_plus[15:8];
          s_nxt.pend_lo = sp_plus[7:0];
          s_nxt.pend_lo_valid = 1'b1;
          s_nxt.st = ST_CMD;
        end
      end
      ST_RESUME: begin
        // pull index high, then return from interrupt
        // the stacked registers may have been rewritten; unstack in reverse order
        if (s_r.step == 2'b00) begin
          s_nxt.req.pull_h = 1'b1;
          s_nxt.step = 2'b01;
        end else if (req_ack && s_r.req.pull_h) begin
          s_nxt.req.pull_h = 1'b0;
          s_nxt.req.int_ret = 1'b1;
        end else if (req_ack && s_r.req.int_ret) begin
          s_nxt.req.int_ret = 1'b0;
          s_nxt.step = 2'b00;
          s_nxt.st = ST_USER;
        end
      end
      ST_USER: begin
        // user code runs; monitor is idle until the next reset
        // a warm reset returns to the break, a power-on one to the security bytes
        s_nxt.st = ST_USER;
      end
      default: begin
        // unused state code: restart the stacking sequence
        s_nxt.st = ST_STACK;
      end
    endcase
    // locked flash: invalid data and illegal fetch reset
    // while locked the raw byte never reaches the bus; reads see a fixed code
    if (flash_rd_i) begin
      s_nxt.rdata = s_r.unlocked ? flash_rdata_i : INVALID_BYTE;
    end
    // one-cycle pulse; the reset controller stretches it as it needs
    if (fetch_blocked) begin
      s_nxt.illegal = 1'b1;
    end
  end

  // ==========================================================
  // state register; unlock only cleared by power-on
  // any other reset, such as an illegal address reset, restarts stacking
  // but keeps the verdict, so the break follows at once without new bytes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_r.st <= ST_STACK;
      s_r.step <= 2'b00;
      s_r.tx_valid <= 1'b0;
      s_r.tx_data <= 8'h00;
      s_r.tx_break <= 1'b0;
      s_r.pend_lo <= 8'h00;
      s_r.pend_lo_valid <= 1'b0;
      s_r.req <= '0;
      s_r.rdata <= 8'h00;
      s_r.illegal <= 1'b0;
      // verdict and erase flag survive warm resets
      if (por_i) begin
        s_r.unlocked <= 1'b0;
        s_r.sec_done <= 1'b0;
        s_r.erased <= 1'b0;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  // every output except monitor_mode_o (a decode of st) and sec_addr_o (base plus compare index) comes from a state-word flip-flop or a constant
  assign tx_valid_o = s_r.tx_valid;
  assign tx_data_o = s_r.tx_data;
  assign tx_break_o = s_r.tx_break;
  assign cpu_req_o = s_r.req;
  assign flash_rdata_o = s_r.rdata;
  assign illegal_reset_o = s_r.illegal;
  assign erased_o = s_r.erased;
  assign unlocked_o = s_r.unlocked;
  assign status_ram_o = status_img;
  assign monitor_mode_o = (s_r.st != ST_USER);

endmodule : monitor_security_gate

// ### sim/mon_gate_sva.sv
// Purpose: port assertions for the monitor security gate
// Assumes: one clock, sync active-high reset
// Notes: bound into every gate instance
`timescale 1ns/1ps
module mon_gate_sva
  import mon_gate_pkg::*;
(
  // clock, reset and cpu handshake
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic cpu_ack_i,
  input wire cpu_req_t cpu_req_o,
  // link transmit side
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic tx_break_o,
  input wire logic [7:0] tx_data_o,
  // flash gating and status
  input wire logic flash_rd_i,
  input wire logic flash_fetch_i,
  input wire logic illegal_reset_o,
  input wire logic unlocked_o,
  input wire logic [7:0] flash_rdata_o,
  input wire logic [7:0] status_ram_o
);
  // ====
  // all checks share the system clock
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_break_o, tx_data_o}); endproperty
  a_hold: assert property (p_hold) else $error("tx item moved");
  property p_lrd; flash_rd_i && !unlocked_o |=> flash_rdata_o == INVALID_BYTE; endproperty
  a_lrd: assert property (p_lrd) else $error("locked read");
  property p_ill; flash_fetch_i && !unlocked_o |=> illegal_reset_o; endproperty
  a_ill: assert property (p_ill) else $error("no illegal reset");
  property p_stat; status_ram_o == {1'b0, unlocked_o, 6'h00}; endproperty
  a_stat: assert property (p_stat) else $error("status bit");
  property p_keep; $fell(rst_i) && !$past(por_i) && $past(unlocked_o) |-> unlocked_o; endproperty
  a_keep: assert property (p_keep) else $error("unlock lost");
  property p_clr; $fell(rst_i) && $past(por_i) |-> !unlocked_o; endproperty
  a_clr: assert property (p_clr) else $error("unlock kept");
  property p_push; cpu_req_o.sw_int && cpu_ack_i |=> cpu_req_o.push_h; endproperty
  a_push: assert property (p_push) else $error("no push");
  property p_rti; cpu_req_o.pull_h && cpu_ack_i |=> cpu_req_o.int_ret; endproperty
  a_rti: assert property (p_rti) else $error("no return");
  property p_one; $onehot0(cpu_req_o); endproperty
  a_one: assert property (p_one) else $error("two requests");
  // main scenarios reached
  c_ill: cover property (illegal_reset_o);
  c_run: cover property (cpu_req_o.int_ret && cpu_ack_i);
  c_brk: cover property (tx_break_o && tx_ready_i);
endmodule : mon_gate_sva
bind monitor_security_gate mon_gate_sva mon_gate_sva_i (.ref_clk_i, .rst_i, .por_i,
  .cpu_ack_i, .cpu_req_o, .tx_valid_o, .tx_ready_i, .tx_break_o, .tx_data_o,
  .flash_rd_i, .flash_fetch_i, .illegal_reset_o, .unlocked_o, .flash_rdata_o, .status_ram_o);

// ### sim/mon_host.sv
// Purpose: host model on the byte-level monitor link
// Assumes: one tx item taken per ready pulse
// Notes: stall sets the wait before each item
`timescale 1ns/1ps
module mon_host (
  // clock
  input wire logic ref_clk_i,
  // gate transmit side
  input wire logic gate_tx_valid_i,
  input wire logic gate_tx_break_i,
  input wire logic [7:0] gate_tx_data_i,
  // host drives
  output logic host_valid_o = 1'b0,
  output logic [7:0] host_data_o = 8'h5a,
  output logic host_ready_o = 1'b0
);
  int stall = 0;
  int w = 0;
  logic [8:0] got[$];  // bit 8 is the break flag
  // ====
  // accept each item after stall cycles
  always @(posedge ref_clk_i) begin
    host_ready_o <= 1'b0;
    w <= 0;
    if (gate_tx_valid_i && !host_ready_o && w < stall) begin
      w <= w + 1;
    end else if (gate_tx_valid_i && !host_ready_o) begin
      host_ready_o <= 1'b1;
      got.push_back({gate_tx_break_i, gate_tx_data_i});
    end
  end
  // one byte; the released line shows the inverse
  task send(input logic [7:0] b);
    repeat (2) @(posedge ref_clk_i);
    host_valid_o <= 1'b1;
    host_data_o <= b;
    @(posedge ref_clk_i);
    host_valid_o <= 1'b0;
    host_data_o <= ~b;
  endtask : send
endmodule : mon_host

// ### sim/tb_monitor_security_gate.sv
// Purpose: self-checking bench for the monitor security gate
// Assumes: bench plays cpu and flash, mon_host the link
// Notes: flash key is 30h plus byte index
`timescale 1ns/1ps
module tb_monitor_security_gate;
  import mon_gate_pkg::*;
  logic clk = 0, rst = 1, por = 1, ack = 0, frd = 0, fetch = 0, erase = 0;
  logic [15:0] sp = 16'h01f3;
  wire rx_v, tx_r, tx_v, tx_b, ill, erased, unl, mon;
  wire [7:0] rx_d, tx_d, rdo, status;
  wire [15:0] sa;
  cpu_req_t req;
  cpu_req_t ops[$];
  int err_count = 0, samples_checked = 0, cyc = 0;
  // ====
  // key is non-blank
  monitor_security_gate monitor_security_gate_i (.ref_clk_i(clk), .rst_i(rst), .por_i(por),
    .rx_valid_i(rx_v), .rx_data_i(rx_d), .tx_ready_i(tx_r), .tx_valid_o(tx_v),
    .tx_data_o(tx_d), .tx_break_o(tx_b), .sp_i(sp), .cpu_ack_i(ack), .cpu_req_o(req),
    .sec_addr_o(sa), .sec_data_i(8'h30 + 8'(sa - SEC_BASE_ADDR)), .flash_rd_i(frd),
    .flash_rdata_i(8'h5c), .flash_rdata_o(rdo), .flash_fetch_i(fetch),
    .illegal_reset_o(ill), .mass_erase_done_i(erase), .erased_o(erased),
    .status_ram_o(status), .unlocked_o(unl), .monitor_mode_o(mon));
  mon_host mon_host_i (.ref_clk_i(clk), .gate_tx_valid_i(tx_v), .gate_tx_break_i(tx_b),
    .gate_tx_data_i(tx_d), .host_valid_o(rx_v), .host_data_o(rx_d), .host_ready_o(tx_r));
  initial forever #5 clk = ~clk;
  // cpu acks and logs each request; timeout
  always @(posedge clk) begin
    ack <= (|req === 1'b1) && !ack;
    if ((|req === 1'b1) && !ack) ops.push_back(req);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      summarize();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task pop(input logic [8:0] exp);
    logic [8:0] v;
    v = 9'h1ff;
    repeat (60) if (mon_host_i.got.size() == 0) @(posedge clk);
    if (mon_host_i.got.size() > 0) v = mon_host_i.got.pop_front();
    chk(16'(v), 16'(exp));
  endtask : pop
  // reset, stacking, security bytes on power-on only, break
  task enter(input logic p, input logic [7:0] last);
    @(posedge clk);
    rst <= 1;
    por <= p;
    repeat (5) @(posedge clk);
    ops.delete();
    mon_host_i.got.delete();
    rst <= 0;
    por <= 0;
    repeat (8) @(posedge clk);
    chk(16'({ops[0], ops[1]}), 16'h84);
    for (int i = 0; i < 8 && p; i++) begin
      chk(16'(tx_v), 16'h0);
      mon_host_i.send(i < 7 ? 8'h30 + 8'(i) : last);
    end
    pop(9'h100);
  endtask : enter
  task acc(input logic [7:0] exp, input logic il);
    @(posedge clk);
    frd <= 1;
    fetch <= 1;
    @(posedge clk);
    frd <= 0;
    fetch <= 0;
    #1;
    chk(16'(rdo), 16'(exp));
    chk(16'(ill), 16'(il));
  endtask : acc
  task t_fail;
    enter(1'b1, 8'h00);
    chk(16'(unl), 16'h0);
    chk(16'(mon), 16'h1);
    acc(INVALID_BYTE, 1'b1);
    @(posedge clk);
    erase <= 1;
    @(posedge clk);
    erase <= 0;
    @(posedge clk);
    chk(16'(erased), 16'h1);
  endtask : t_fail
  task t_pass;
    enter(1'b1, 8'h37);
    chk(16'(status[6]), 16'h1);
    acc(8'h5c, 1'b0);
  endtask : t_pass
  task t_warm;
    mon_host_i.stall = 3;
    enter(1'b0, 8'h00);
    chk(16'(unl), 16'h1);
    mon_host_i.stall = 0;
  endtask : t_warm
  task t_cmd;
    logic [15:0] x;
    x = sp + SP_RD_OFS;
    mon_host_i.send(READ_SP_OPCODE);
    pop({1'b0, READ_SP_OPCODE});
    pop({1'b0, x[15:8]});
    pop({1'b0, x[7:0]});
    ops.delete();
    // host keeps the stacked registers, so the run resumes the stopped code
    mon_host_i.send(RUN_OPCODE);
    pop({1'b0, RUN_OPCODE});
    repeat (10) @(posedge clk);
    chk(16'({ops[0], ops[1]}), 16'h21);
    chk(16'(mon), 16'h0);
  endtask : t_cmd
  task summarize;
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    t_fail();
    t_pass();
    t_warm();
    t_cmd();
    summarize();
  end
endmodule : tb_monitor_security_gate
